// [common/sar_pkg.sv]
// Package for the serial converter readout: frame counts, mode and state codes.
// Assumes a system clock of 25 MHz shared by both ends.
package sar_pkg;
  localparam int RES_BITS = 12;
  localparam int LEAD_ZEROS = 3;
  localparam logic [4:0] FRAME_FALLS = 5'h10;
  localparam logic [4:0] TRACK_RISE = 5'h0D;
  localparam logic [4:0] MODE_FALL = 5'h0A;
  localparam logic [4:0] NOISE_FALL = 5'h02;
  localparam int CLK_SYS_PERIOD_NS = 40;
  localparam int ACQ_TIME_NS = 350;
  localparam int ACQ_CYCLES =
    (ACQ_TIME_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES = 4;
  localparam int FRAME_SCLKS = 20;
  localparam logic [RES_BITS-1:0] RESULT_RESET = 12'h000;
  typedef enum logic [1:0] {
    SAR_MODE_NORMAL = 2'b01,
    SAR_MODE_SHUTDOWN = 2'b10
  } sar_mode_e;
  typedef enum logic [3:0] {
    SAR_H_IDLE = 4'b0001,
    SAR_H_FRAME = 4'b0010,
    SAR_H_QUIET = 4'b0100,
    SAR_H_DONE = 4'b1000
  } sar_host_state_e;
endpackage : sar_pkg

// [common/sar_link_if.sv]
// Three-wire link between the converter end and the host end.
// Resolves the result line from its output enable; a pull-down holds it low
// while released.
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
  logic frame_sel_n;
  logic sclk;
  logic serial_result_out;
  logic serial_result_oe;
  wire logic serial_result_wire;
  // Released line reads as the pull-down level
  assign serial_result_wire = serial_result_oe ? serial_result_out : 1'b0;
  modport device (input frame_sel_n, input sclk,
    output serial_result_out, output serial_result_oe);
  modport host (output frame_sel_n, output sclk,
    input serial_result_wire);
endinterface : sar_link_if
`default_nettype wire

// [verilog/sar_device.sv]
// Converter end: samples the link pins, runs the conversion and shifts out.
// Assumes link pins are asynchronous to clk_sys_in; result comes from a port.
// Summary of operation
// - Select fall samples input, starts conversion
// - Select fall starts driving result line
// - Thirteenth rising clock returns to track
// - Host waits 350ns after thirteenth rise
// - Release line after sixteenth fall or select rise
// - Host keeps quiet time between conversions
// - Host applies at least sixteen clocks per frame
// - Bits change on falls, captured next fall
// - Three zeros then twelve bits MSB first
// - Early select fall may add fourth zero
// - Host spaces select falls by hold+track+pad
// - Host uses twenty clock frame
// - Shorter frames allowed if timing met
// - Result is straight binary code
// - Successive approximation trial word is result
// - Select low enters normal mode, converts
// - Rise after second, before tenth fall enters shutdown
// - Shutdown holds until select goes low
// - Rise before second fall keeps mode
// - Rise after tenth aborts, stays normal
// - First result after shutdown invalid
`timescale 1ns/1ps
`default_nettype none
module sar_device
  import sar_pkg::*;
#(
  parameter int RESULT_WIDTH = 12
) (
  // Clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Analog stand-in: input value as a code, compared with each trial word
  input wire logic [RESULT_WIDTH-1:0] sample_code_in,
  // Link
  sar_link_if.device link,
  // Status
  output logic [RESULT_WIDTH-1:0] result_out,
  output logic result_valid_out,
  output logic shutdown_out,
  output logic tracking_out
);
  import sar_pkg::*;

  initial begin
    if (RESULT_WIDTH != RES_BITS) $error("RESULT_WIDTH must be 12");
  end

  // Pin synchronisers
  logic cs_s1_reg, cs_s2_reg, cs_d_reg;
  logic ck_s1_reg, ck_s2_reg, ck_d_reg;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_d_reg <= 1'b1;
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_d_reg <= 1'b0;
    end else if (clk_en_in) begin
      cs_s1_reg <= link.frame_sel_n;
      cs_s2_reg <= cs_s1_reg;
      cs_d_reg <= cs_s2_reg;
      ck_s1_reg <= link.sclk;
      ck_s2_reg <= ck_s1_reg;
      ck_d_reg <= ck_s2_reg;
    end
  end

  logic cs_fall, cs_rise, ck_rise, ck_fall;
  assign cs_fall = cs_d_reg & ~cs_s2_reg;
  assign cs_rise = ~cs_d_reg & cs_s2_reg;
  assign ck_rise = ~ck_d_reg & ck_s2_reg & ~cs_s2_reg;
  assign ck_fall = ck_d_reg & ~ck_s2_reg & ~cs_s2_reg;

  // Frame state
  logic [4:0] rise_cnt_reg, rise_cnt_next;
  logic [4:0] fall_cnt_reg, fall_cnt_next;
  logic bit_reg, bit_next;
  logic up_reg, up_next;
  logic prior_shut_reg, prior_shut_next;
  logic [4:0] data_idx;
  logic [RESULT_WIDTH-1:0] trial_reg, trial_next;
  logic [3:0] bit_idx_reg, bit_idx_next;
  logic drive_reg, drive_next;
  logic track_reg, track_next;
  logic warm_reg, warm_next;
  sar_mode_e mode_reg, mode_next;
  logic [RESULT_WIDTH-1:0] result_reg, result_next;
  logic valid_reg, valid_next;

  // Next-state logic for the conversion and shift
  always_comb begin
    rise_cnt_next = rise_cnt_reg;
    fall_cnt_next = fall_cnt_reg;
    bit_next = bit_reg;
    up_next = up_reg;
    prior_shut_next = prior_shut_reg;
    data_idx = 5'(LEAD_ZEROS + RESULT_WIDTH - 1) - (fall_cnt_reg + 5'h01);
    trial_next = trial_reg;
    bit_idx_next = bit_idx_reg;
    drive_next = drive_reg;
    track_next = track_reg;
    warm_next = warm_reg;
    mode_next = mode_reg;
    result_next = result_reg;
    valid_next = 1'b0;
    if (cs_s2_reg && !cs_rise) begin
      rise_cnt_next = 5'h00;
      fall_cnt_next = 5'h00;
    end
    if (cs_fall) begin
      track_next = 1'b0;
      drive_next = 1'b1;
      mode_next = SAR_MODE_NORMAL;
      warm_next = up_reg;
      prior_shut_next = (mode_reg == SAR_MODE_SHUTDOWN);
      trial_next = {1'b1, {(RESULT_WIDTH-1){1'b0}}};
      bit_idx_next = 4'(RESULT_WIDTH - 1);
      bit_next = 1'b0;
      rise_cnt_next = 5'h00;
      fall_cnt_next = 5'h00;
    end else if (cs_rise) begin
      drive_next = 1'b0;
      track_next = 1'b1;
      if (fall_cnt_reg >= NOISE_FALL && fall_cnt_reg < MODE_FALL) begin
        mode_next = SAR_MODE_SHUTDOWN;
        up_next = 1'b0;
      end else if (fall_cnt_reg < NOISE_FALL) begin
        // Noise pulse: restore the mode held before this frame
        mode_next = prior_shut_reg ? SAR_MODE_SHUTDOWN : SAR_MODE_NORMAL;
      end // keeps normal
    end else begin
      if (ck_rise) begin
        rise_cnt_next = rise_cnt_reg + 5'h01;
        if (rise_cnt_reg + 5'h01 == TRACK_RISE) begin
          track_next = 1'b1;
        end
        // One trial bit decided per rising edge until the word is done
        if (!track_reg && rise_cnt_reg < 5'(RESULT_WIDTH)) begin
          if (sample_code_in < trial_reg) begin
            trial_next[bit_idx_reg] = 1'b0;
          end
          if (bit_idx_reg != 4'h0) begin
            trial_next[bit_idx_reg - 4'h1] = 1'b1;
            bit_idx_next = bit_idx_reg - 4'h1;
          end
        end
        if (rise_cnt_reg + 5'h01 == TRACK_RISE) begin
          if (warm_reg) begin
            result_next = trial_next;
            valid_next = 1'b1;
          end
        end
      end
      if (ck_fall) begin
        fall_cnt_next = fall_cnt_reg + 5'h01;
        // Leading zeros, then each decided trial bit, MSB first
        bit_next = 1'b0;
        if (data_idx < 5'(RESULT_WIDTH)) begin
          bit_next = trial_reg[data_idx[3:0]];
        end
        if (fall_cnt_reg + 5'h01 == MODE_FALL) begin
          up_next = 1'b1;
        end
        if (fall_cnt_reg + 5'h01 == FRAME_FALLS) begin
          drive_next = 1'b0;
        end
      end
    end
  end

  // Registers for the frame state
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rise_cnt_reg <= 5'h00;
      fall_cnt_reg <= 5'h00;
      bit_reg <= 1'b0;
      up_reg <= 1'b0;
      prior_shut_reg <= 1'b0;
      trial_reg <= RESULT_RESET;
      bit_idx_reg <= 4'h0;
      drive_reg <= 1'b0;
      track_reg <= 1'b1;
      warm_reg <= 1'b0;
      mode_reg <= SAR_MODE_NORMAL;
      result_reg <= RESULT_RESET;
      valid_reg <= 1'b0;
    end else if (clk_en_in) begin
      rise_cnt_reg <= rise_cnt_next;
      fall_cnt_reg <= fall_cnt_next;
      bit_reg <= bit_next;
      up_reg <= up_next;
      prior_shut_reg <= prior_shut_next;
      trial_reg <= trial_next;
      bit_idx_reg <= bit_idx_next;
      drive_reg <= drive_next;
      track_reg <= track_next;
      warm_reg <= warm_next;
      mode_reg <= mode_next;
      result_reg <= result_next;
      valid_reg <= valid_next;
    end
  end

  // Data bit register; leading bits are zero
  assign link.serial_result_out = bit_reg;
  assign link.serial_result_oe = drive_reg;
  assign result_out = result_reg;
  assign result_valid_out = valid_reg;
  assign shutdown_out = mode_reg[1];
  assign tracking_out = track_reg;
endmodule : sar_device
`default_nettype wire

// [verilog/sar_host.sv]
// Host end: makes the link clock by dividing clk_sys_in and reads frames.
// Assumes a start pulse from user logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sar_host
  import sar_pkg::*;
#(
  parameter int FRAME_LEN = 20,
  parameter int HALF_DIV = 4
) (
  // Clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // User request
  input wire logic start_in,
  input wire logic [4:0] abort_fall_in,
  // Link
  sar_link_if.host link,
  // User answer
  output logic [11:0] data_out,
  output logic data_valid_out,
  output logic busy_out
);
  import sar_pkg::*;

  initial begin
    if (FRAME_LEN < 16 || FRAME_LEN > 31 || HALF_DIV < 1 || HALF_DIV > 15)
      $error("unsupported host parameters");
  end

  // Result line synchroniser
  logic sd_s1_reg, sd_s2_reg;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sd_s1_reg <= 1'b0;
      sd_s2_reg <= 1'b0;
    end else if (clk_en_in) begin
      sd_s1_reg <= link.serial_result_wire;
      sd_s2_reg <= sd_s1_reg;
    end
  end

  sar_host_state_e st_reg, st_next;
  logic [3:0] div_reg, div_next;
  logic sclk_reg, sclk_next;
  logic cs_n_reg, cs_n_next;
  logic [4:0] falls_reg, falls_next;
  logic [15:0] cap_reg, cap_next;
  logic [11:0] data_reg, data_next;
  logic valid_reg, valid_next;

  // Frame sequencer; first sclk fall after select fall, bits taken on falls
  always_comb begin
    st_next = st_reg;
    div_next = div_reg;
    sclk_next = sclk_reg;
    cs_n_next = cs_n_reg;
    falls_next = falls_reg;
    cap_next = cap_reg;
    data_next = data_reg;
    valid_next = 1'b0;
    case (st_reg)
      SAR_H_IDLE: begin
        sclk_next = 1'b1;
        if (start_in) begin
          cs_n_next = 1'b0;
          div_next = 4'h0;
          falls_next = 5'h00;
          st_next = SAR_H_FRAME;
        end
      end
      SAR_H_FRAME: begin
        div_next = div_reg + 4'h1;
        if (div_reg == 4'(HALF_DIV - 1)) begin
          div_next = 4'h0;
          sclk_next = ~sclk_reg;
          if (sclk_reg) begin
            falls_next = falls_reg + 5'h01;
            // Each of the first sixteen falls takes the bit shifted out on the previous fall
            if (falls_reg < FRAME_FALLS) begin
              cap_next = {cap_reg[14:0], sd_s2_reg};
            end
            if (falls_reg + 5'h01 == 5'(FRAME_LEN)) begin
              st_next = SAR_H_DONE;
            end
          end
          if (abort_fall_in != 5'h00 && falls_reg == abort_fall_in) begin
            cs_n_next = 1'b1;
            st_next = SAR_H_DONE;
          end
        end
      end
      SAR_H_DONE: begin
        cs_n_next = 1'b1;
        sclk_next = 1'b1;
        data_next = cap_reg[12:1];
        valid_next = (falls_reg >= FRAME_FALLS);
        st_next = SAR_H_QUIET;
        div_next = 4'h0;
      end
      SAR_H_QUIET: begin
        div_next = div_reg + 4'h1;
        if (div_reg == 4'(ACQ_CYCLES)) st_next = SAR_H_IDLE;
      end
      default: st_next = SAR_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= SAR_H_IDLE;
      div_reg <= 4'h0;
      sclk_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      falls_reg <= 5'h00;
      cap_reg <= 16'h0000;
      data_reg <= 12'h000;
      valid_reg <= 1'b0;
    end else if (clk_en_in) begin
      st_reg <= st_next;
      div_reg <= div_next;
      sclk_reg <= sclk_next;
      cs_n_reg <= cs_n_next;
      falls_reg <= falls_next;
      cap_reg <= cap_next;
      data_reg <= data_next;
      valid_reg <= valid_next;
    end
  end

  assign link.sclk = sclk_reg;
  assign link.frame_sel_n = cs_n_reg;
  assign data_out = data_reg;
  assign data_valid_out = valid_reg;
  assign busy_out = (st_reg != SAR_H_IDLE);
endmodule : sar_host
`default_nettype wire

// [test/sar_link_properties.sv]
// Checker for the three-wire link between the converter and host ends.
// Assumes link signals are sampled on clk_sys_in, reset async active high.
`timescale 1ns/1ps
`default_nettype none
module sar_link_props
  import sar_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Link
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  import sar_pkg::*;
  logic sclk_reg;
  logic sclk_next;
  logic [4:0] falls_reg;
  logic [4:0] falls_next;
  logic [7:0] gap_reg;
  logic [7:0] gap_next;
  logic [2:0] age_reg;
  logic [2:0] age_next;
  logic fall;
  logic rise;
  // Count clock falls per frame, cycles since a fall and since 12th rise
  always_comb begin
    sclk_next = sclk;
    fall = sclk_reg && !sclk;
    rise = !sclk_reg && sclk;
    falls_next = frame_sel_n ? 5'h00 : falls_reg + 5'(fall);
    age_next = fall ? 3'h0 : age_reg + 3'(age_reg != 3'h7);
    gap_next = (rise && falls_reg == TRACK_RISE - 5'h01) ? 8'h00 :
      gap_reg + 8'(gap_reg != 8'hFF);
  end
  // Register the helper counters
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_reg <= 1'b1;
      falls_reg <= 5'h00;
      age_reg <= 3'h7;
      gap_reg <= 8'hFF;
    end else begin
      sclk_reg <= sclk_next;
      falls_reg <= falls_next;
      age_reg <= age_next;
      gap_reg <= gap_next;
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // One bit time of a zero on the result line
  sequence zero_bit;
    !serial_result_out [*8];
  endsequence
  a_drive_on_select: assert property ($fell(frame_sel_n) |-> ##[2:4] serial_result_oe) else $error("result line not driven after select fall");
  a_drive_in_frame: assert property (!frame_sel_n [*4] ##0 (falls_reg inside {[1:15]}) |-> serial_result_oe) else $error("result line dropped inside frame");
  a_lead_zeros: assert property ($rose(serial_result_oe) |-> zero_bit ##1 zero_bit) else $error("leading zeros missing");
  a_release_late: assert property (falls_reg > FRAME_FALLS |-> !serial_result_oe) else $error("result line driven past sixteenth fall");
  a_release_rise: assert property ($rose(frame_sel_n) |-> ##[0:4] !serial_result_oe) else $error("result line held after select rise");
  a_idle_released: assert property (frame_sel_n [*5] |-> !serial_result_oe) else $error("result line driven while deselected");
  a_bit_on_fall: assert property (serial_result_oe && $past(serial_result_oe) && $changed(serial_result_out) |-> age_reg inside {[0:5]}) else $error("result bit moved away from a clock fall");
  a_twenty_falls: assert property ($rose(frame_sel_n) && falls_reg > 5'h0F |-> falls_reg == 5'(FRAME_SCLKS)) else $error("full frame not twenty clocks");
  a_track_gap: assert property ($fell(frame_sel_n) |-> gap_reg >= 8'(ACQ_CYCLES)) else $error("select fell too soon after track start");
endmodule : sar_link_props
`default_nettype wire

// [test/serial_sar_adc_readout_tb.sv]
// Testbench joining converter and host ends across the link interface.
// Assumes both ends share clk_sys_in; host makes the link clock itself.
`timescale 1ns/1ps
`default_nettype none
module serial_sar_adc_readout_tb;
  import sar_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic start_in = 1'b0;
  logic [4:0] abort_fall_in = 5'h00;
  logic [11:0] sample_code_in = 12'h000;
  logic [11:0] result_out;
  logic [11:0] data_out;
  logic result_valid_out;
  logic shutdown_out;
  logic tracking_out;
  logic data_valid_out;
  logic busy_out;
  logic saw_hold = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_valid = 0;
  logic [11:0] codes [4] = '{12'h000, 12'hFFF, 12'h800, 12'h001};
  sar_link_if link ();
  sar_device u_sar_device (.clk_sys_in, .rst_in, .clk_en_in(1'b1),
    .sample_code_in, .link(link), .result_out, .result_valid_out,
    .shutdown_out, .tracking_out);
  sar_host u_sar_host (.clk_sys_in, .rst_in, .clk_en_in(1'b1), .start_in,
    .abort_fall_in, .link(link), .data_out, .data_valid_out, .busy_out);
  sar_link_props u_sar_link_props (.clk_sys_in, .rst_in,
    .frame_sel_n(link.frame_sel_n), .sclk(link.sclk),
    .serial_result_out(link.serial_result_out),
    .serial_result_oe(link.serial_result_oe));
  // Free-running system clock
  always #(CLK_SYS_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;
  // Count valid pulses and note hold phases
  always @(posedge clk_sys_in) begin
    if (result_valid_out === 1'b1) n_valid <= n_valid + 1;
    if (tracking_out === 1'b0) saw_hold <= 1'b1;
  end
  // Compare one value and log any difference
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check
  // Print counts and the verdict, then stop
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // Run one host frame, optionally cut short, and check the outcome
  task automatic frame(input logic [11:0] code, input logic [4:0] abort,
      input int want_valid, input logic want_shut);
    int i;
    n_valid = 0;
    saw_hold = 1'b0;
    sample_code_in = code;
    abort_fall_in = abort;
    start_in = 1'b1;
    @(posedge clk_sys_in) #1;
    start_in = 1'b0;
    i = 0;
    while (busy_out !== 1'b0 && i < 2000) begin
      @(posedge clk_sys_in) #1;
      i++;
    end
    if (i == 2000) n_mismatch++;
    repeat (6) @(posedge clk_sys_in);
    #1;
    check(12'(n_valid), 12'(want_valid));
    check({11'h000, shutdown_out}, {11'h000, want_shut});
    if (abort == 5'h00) begin
      check({11'h000, saw_hold}, 12'h001);
      check({11'h000, tracking_out}, 12'h001);
      if (want_valid == 1) begin
        check(data_out, code);
        check(result_out, code);
      end
    end
  endtask : frame
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    check({11'h000, shutdown_out}, 12'h000);
    check({11'h000, tracking_out}, 12'h001);
    frame(12'h3C5, 5'h00, 0, 1'b0);
    frame(12'hA5C, 5'h00, 1, 1'b0);
    foreach (codes[k]) frame(codes[k], 5'h00, 1, 1'b0);
    frame(12'h123, 5'h0C, 0, 1'b0);
    frame(12'h123, 5'h01, 0, 1'b0);
    frame(12'h123, 5'h05, 0, 1'b1);
    frame(12'h123, 5'h01, 0, 1'b1);
    frame(12'h5A5, 5'h00, 0, 1'b0);
    frame(12'h5A5, 5'h00, 1, 1'b0);
    final_report();
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_mismatch++;
    final_report();
  end
endmodule : serial_sar_adc_readout_tb
`default_nettype wire
